// >>> rtl/sync_pacer_pkg.sv
// constants shared by the sync pacer design
package sync_pacer_pkg;

  // *********************************************************
  // timing
  // *********************************************************
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;
  localparam int unsigned GLITCH_MIN_NS  = 258;
  // samples a level must hold: a pulse just under the limit can still
  // straddle floor(limit/period)+1 samples, so one more is required
  localparam int unsigned GLITCH_CYCLES  =
    (GLITCH_MIN_NS - 1) / CLK_PERIOD_NS + 2;
  // internal pacing period when free running (cycles)
  localparam int unsigned INT_PERIOD_CYC = 4000;
  // sync edges older than this are stale; fall back to internal pacing
  localparam int unsigned SYNC_LOSS_CYC  = 4000;
  // serial bit period in cycles
  localparam int unsigned BAUD_DIV       = 8;

  // *********************************************************
  // frame layout
  // *********************************************************
  localparam int unsigned DATA_BITS      = 8;
  localparam int unsigned FRAME_BITS     = 11; // start, data, parity, stop
  localparam int unsigned RESET_OVS      = 4;  // oversample count reset

endpackage : sync_pacer_pkg

// >>> rtl/uart_frame_if.sv
// handshake between pacer core and frame transmitter
`timescale 1ns/1ps
interface uart_frame_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : uart_frame_if

// >>> rtl/uart_frame_tx.sv
// serial frame transmitter: start, 8 data, even parity, stop
`timescale 1ns/1ps
module uart_frame_tx #(
  parameter int unsigned DIV = sync_pacer_pkg::BAUD_DIV
) (
  input  wire logic   clk_i,
  input  wire logic   reset_i,
  uart_frame_if.dst   frm,
  output logic        txd_o
);
  typedef enum logic [0:0] {IDLE = 1'b0, SEND = 1'b1} tx_state_t;

  // the bit-time counter below is only 16 bits wide
  if (DIV < 2 || DIV > 65536) begin : g_div_chk
    $error("DIV must lie between 2 and 65536");
  end

  tx_state_t   state_r,  state_nxt;
  logic [10:0] shreg_r,  shreg_nxt;
  logic [3:0]  nbit_r,   nbit_nxt;
  logic [15:0] div_r,    div_nxt;
  logic        txd_r,    txd_nxt;

  assign frm.ready = (state_r == IDLE);
  assign txd_o     = txd_r;

  // ***************************************************
  // shift engine
  // ***************************************************
  // lsb first; parity bit is xor of data so total ones is even
  always_comb begin
    state_nxt = state_r;
    shreg_nxt = shreg_r;
    nbit_nxt  = nbit_r;
    div_nxt   = div_r;
    txd_nxt   = txd_r;
    case (state_r)
      IDLE: begin
        txd_nxt = 1'b1;
        if (frm.valid) begin
          shreg_nxt = {1'b1, ^frm.data, frm.data, 1'b0};
          state_nxt = SEND;
          nbit_nxt  = 4'h0;
          div_nxt   = 16'h0000;
        end
      end
      SEND: begin
        txd_nxt = shreg_r[0];
        if (div_r == 16'(DIV - 1)) begin
          div_nxt   = 16'h0000;
          shreg_nxt = {1'b1, shreg_r[10:1]};
          if (nbit_r == 4'(sync_pacer_pkg::FRAME_BITS - 1)) begin
            state_nxt = IDLE;
          end else begin
            nbit_nxt = nbit_r + 4'h1;
          end
        end else begin
          div_nxt = div_r + 16'h0001;
        end
      end
      default: state_nxt = IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= IDLE;
      shreg_r <= 11'h7FF;
      nbit_r  <= 4'h0;
      div_r   <= 16'h0000;
      txd_r   <= 1'b1;
    end else begin
      state_r <= state_nxt;
      shreg_r <= shreg_nxt;
      nbit_r  <= nbit_nxt;
      div_r   <= div_nxt;
      txd_r   <= txd_nxt;
    end
  end

  AST_FRAME_START: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_r == IDLE && frm.valid) |=> ##1 !txd_o)
    else $error("frame did not open with a start bit");

endmodule : uart_frame_tx

// >>> rtl/sync_pacer.sv
// external sync pacer: filter, capture, message start, fallback timing
`timescale 1ns/1ps
module sync_pacer #(
  parameter int unsigned SAMPLE_W  = 16,
  parameter bit          DIFF_SYNC = 1'b0,
  parameter int unsigned INT_PER   = sync_pacer_pkg::INT_PERIOD_CYC,
  parameter int unsigned LOSS_CYC  = sync_pacer_pkg::SYNC_LOSS_CYC
) (
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  input  wire logic                sync_i,
  input  wire logic                sync_n_i,
  input  wire logic [SAMPLE_W-1:0] sample_i,
  output logic                     sample_req_o,
  output logic                     ext_mode_o,
  output logic                     ovs_en_o,
  output logic [SAMPLE_W-1:0]      record_o,
  output logic                     txd_o
);
  localparam int unsigned NBYTES = SAMPLE_W / sync_pacer_pkg::DATA_BITS;
  localparam int unsigned GC     = sync_pacer_pkg::GLITCH_CYCLES;

  typedef enum logic [1:0] {
    MSG_IDLE = 2'b00,
    MSG_SEND = 2'b01,
    MSG_WAIT = 2'b10
  } msg_state_t;

  // elaboration checks: byte framing, sample width limit and minimum periods
  if (SAMPLE_W % 8 != 0 || SAMPLE_W == 0 || SAMPLE_W > 64) begin : g_w_chk
    $error("SAMPLE_W must be a multiple of 8 up to 64");
  end
  if (INT_PER < 32 || LOSS_CYC < 4) begin : g_per_chk
    $error("period parameters too small");
  end

  // ***************************************************
  // input select and synchroniser
  // ***************************************************
  // both legs pass two flops before any gate reads them; skew between
  // the legs then shows only as a short pulse that the filter drops
  logic [1:0] s1_r, s2_r;
  logic       sync_lvl;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s1_r <= 2'b00;
      s2_r <= 2'b00;
    end else begin
      s1_r <= {sync_n_i, sync_i};
      s2_r <= s1_r;
    end
  end

  // pair resolved by polarity compare after synchronising
  assign sync_lvl = DIFF_SYNC ? (s2_r[0] & ~s2_r[1]) : s2_r[0];

  // ***************************************************
  // glitch filter
  // ***************************************************
  // a new level is taken only after it held GC cycles, so shorter
  // pulses never toggle the filtered level
  logic       filt_r,  filt_nxt;
  logic [7:0] gcnt_r,  gcnt_nxt;
  logic       rise, fall;

  always_comb begin
    filt_nxt = filt_r;
    gcnt_nxt = 8'h00;
    if (sync_lvl != filt_r) begin
      if (gcnt_r == 8'(GC - 1)) begin
        filt_nxt = sync_lvl;
      end else begin
        gcnt_nxt = gcnt_r + 8'h01;
      end
    end
  end

  assign rise = filt_nxt & ~filt_r;
  assign fall = ~filt_nxt & filt_r;

  // ***************************************************
  // sync presence and internal rate
  // ***************************************************
  // the mode flag drops after a quiet spell; ext edges restart it
  logic        ext_r,   ext_nxt;
  logic [31:0] quiet_r, quiet_nxt;
  logic [31:0] tick_r,  tick_nxt;
  logic        int_cap, int_msg;

  always_comb begin
    ext_nxt   = ext_r;
    quiet_nxt = quiet_r;
    tick_nxt  = tick_r;
    if (rise || fall) begin
      ext_nxt   = 1'b1;
      quiet_nxt = 32'h0000_0000;
    end else if (quiet_r == 32'(LOSS_CYC - 1)) begin
      ext_nxt = 1'b0;
    end else begin
      quiet_nxt = quiet_r + 32'h0000_0001;
    end
    if (tick_r == 32'(INT_PER - 1)) begin
      tick_nxt = 32'h0000_0000;
    end else begin
      tick_nxt = tick_r + 32'h0000_0001;
    end
  end

  // internal capture at period start, message at half period
  assign int_cap = !ext_r && (tick_r == 32'h0000_0000);
  assign int_msg = !ext_r && (tick_r == 32'(INT_PER / 2));

  // ***************************************************
  // capture and message launch
  // ***************************************************
  // every filtered edge paces, the first one too, except a fall that lands mid-message; internal pacing masked
  // while ext_r is set
  logic                cap_go, msg_go;
  logic [SAMPLE_W-1:0] rec_r, rec_nxt;
  logic                req_r, req_nxt;

  assign cap_go = rise || int_cap;
  assign msg_go = fall || int_msg;

  always_comb begin
    rec_nxt = rec_r;
    req_nxt = cap_go;
    if (cap_go) begin
      rec_nxt = sample_i;
    end
  end

  // ***************************************************
  // message sequencer
  // ***************************************************
  uart_frame_if frm ();
  msg_state_t          mst_r,  mst_nxt;
  logic [SAMPLE_W-1:0] msh_r,  msh_nxt;
  logic [3:0]          mcnt_r, mcnt_nxt;

  // a falling edge that lands mid-message is dropped: the link is busy
  always_comb begin
    mst_nxt   = mst_r;
    msh_nxt   = msh_r;
    mcnt_nxt  = mcnt_r;
    frm.valid = 1'b0;
    frm.data  = msh_r[7:0];
    case (mst_r)
      MSG_IDLE: begin
        if (msg_go) begin
          msh_nxt  = rec_r;
          mcnt_nxt = 4'h0;
          mst_nxt  = MSG_SEND;
        end
      end
      MSG_SEND: begin
        frm.valid = 1'b1;
        if (frm.ready) begin
          mst_nxt = MSG_WAIT;
        end
      end
      MSG_WAIT: begin
        if (frm.ready) begin
          if (mcnt_r == 4'(NBYTES - 1)) begin
            mst_nxt = MSG_IDLE;
          end else begin
            mcnt_nxt = mcnt_r + 4'h1;
            msh_nxt  = msh_r >> 8;
            mst_nxt  = MSG_SEND;
          end
        end
      end
      default: mst_nxt = MSG_IDLE;
    endcase
  end

  uart_frame_tx u_tx (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .frm     (frm),
    .txd_o   (txd_o)
  );

  // ***************************************************
  // registers
  // ***************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      filt_r  <= 1'b0;
      gcnt_r  <= 8'h00;
      ext_r   <= 1'b0;
      quiet_r <= 32'h0000_0000;
      tick_r  <= 32'h0000_0000;
      rec_r   <= '0;
      req_r   <= 1'b0;
      mst_r   <= MSG_IDLE;
      msh_r   <= '0;
      mcnt_r  <= 4'h0;
    end else begin
      filt_r  <= filt_nxt;
      gcnt_r  <= gcnt_nxt;
      ext_r   <= ext_nxt;
      quiet_r <= quiet_nxt;
      tick_r  <= tick_nxt;
      rec_r   <= rec_nxt;
      req_r   <= req_nxt;
      mst_r   <= mst_nxt;
      msh_r   <= msh_nxt;
      mcnt_r  <= mcnt_nxt;
    end
  end

  assign sample_req_o = req_r;
  assign ext_mode_o   = ext_r;
  assign ovs_en_o     = !ext_r;
  assign record_o     = rec_r;

  // ***************************************************
  // assertions
  // ***************************************************
  AST_CAPTURE_ON_RISE: assert property (@(posedge clk_i) disable iff (reset_i)
    rise |=> (sample_req_o && record_o == $past(sample_i)))
    else $error("rising edge did not capture a sample");

  AST_MSG_ON_FALL: assert property (@(posedge clk_i) disable iff (reset_i)
    (fall && mst_r == MSG_IDLE) |=> mst_r == MSG_SEND)
    else $error("falling edge did not start a message");

  AST_GLITCH_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
    $changed(filt_r) |-> $past(sync_lvl) == filt_r &&
    $past(gcnt_r) == 8'(GC - 1) && gcnt_r == 8'h00)
    else $error("filtered level changed without a held input");

  AST_SHORT_PULSE: assert property (@(posedge clk_i) disable iff (reset_i)
    (sync_lvl != filt_r && gcnt_r < 8'(GC - 1)) |=> $stable(filt_r))
    else $error("short pulse passed the filter");

  AST_NO_OVS_EXT: assert property (@(posedge clk_i) disable iff (reset_i)
    (ext_r && rise) |=> !ovs_en_o ##1 !sample_req_o)
    else $error("oversampled or repeated capture during external sync");

  AST_EXT_PACE: assert property (@(posedge clk_i) disable iff (reset_i)
    (ext_r && !rise) |=> !sample_req_o)
    else $error("capture without sync edge while synced");

  AST_FALLBACK: assert property (@(posedge clk_i) disable iff (reset_i)
    (!ext_r && !(rise || fall) && tick_r == 32'h0000_0000) |=>
    sample_req_o && ovs_en_o)
    else $error("internal pacing missed a capture");

  AST_TX_IDLE_HIGH: assert property (@(posedge clk_i) disable iff (reset_i)
    (mst_r == MSG_IDLE && frm.ready) [*3] |-> txd_o)
    else $error("line not idle high between frames");

  COV_EXT_MSG: cover property (@(posedge clk_i) disable iff (reset_i)
    ext_r && fall && mst_r == MSG_IDLE);
  COV_GLITCH: cover property (@(posedge clk_i) disable iff (reset_i)
    sync_lvl != filt_r ##1 sync_lvl == filt_r);
  COV_LOSS: cover property (@(posedge clk_i) disable iff (reset_i)
    $fell(ext_r));

endmodule : sync_pacer

// >>> testbench/sync_source.sv
// timing source model driving the external sync square wave
`timescale 1ns/1ps
module sync_source #(
  parameter int unsigned HALF = 200
) (
  input  wire logic clk_i,
  input  wire logic run_i,
  input  wire logic glitch_i,
  output logic      sync_o
);
  int unsigned cnt_r  = 0;
  logic        wave_r = 1'b0;

  // equal halves: 50% duty at a fixed rate, low while reference invalid
  always @(negedge clk_i) begin
    if (!run_i) begin
      cnt_r  <= 0;
      wave_r <= 1'b0;
    end else if (cnt_r == HALF - 1) begin
      cnt_r  <= 0;
      wave_r <= ~wave_r;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end

  // a glitch flips the line only while the bench holds it
  assign sync_o = wave_r ^ glitch_i;
endmodule : sync_source

// >>> testbench/testbench.sv
// self-checking bench for the external sync pacer
`timescale 1ns/1ps
module testbench;
  localparam int unsigned HALF    = 200;
  localparam int unsigned INT_PER = 200;
  localparam int unsigned LOSS    = 400;
  localparam int unsigned NPER    = 4;
  logic        clk_i    = 1'b0;
  logic        reset_i  = 1'b1;
  logic        run      = 1'b0;
  logic        glitch   = 1'b0;
  logic [15:0] sample_i = 16'h0000;
  logic        sync_w;
  logic        sample_req_o;
  logic        ext_mode_o;
  logic        ovs_en_o;
  logic        txd_o;
  logic [15:0] record_o;
  logic        sample_req_d;
  logic        ext_d;
  logic [15:0] rec_d;
  logic [15:0] exp_rec;
  logic [15:0] exp_q[$];
  logic [7:0]  rx_q[$];
  int          failures = 0;
  int          checks   = 0;
  int          cyc      = 0;
  int          req_cnt  = 0;
  int          last_req = 0;
  int          req_gap  = 0;

  // ******************************************************
  // design, partner and clock
  // ******************************************************
  sync_pacer #(.SAMPLE_W(16), .DIFF_SYNC(1'b0), .INT_PER(INT_PER),
               .LOSS_CYC(LOSS)) uut (
    .clk_i(clk_i), .reset_i(reset_i), .sync_i(sync_w),
    .sync_n_i(1'b0), .sample_i(sample_i), .sample_req_o(sample_req_o),
    .ext_mode_o(ext_mode_o), .ovs_en_o(ovs_en_o), .record_o(record_o),
    .txd_o(txd_o));

  // second pacer on a complementary pair exercises the differential build
  sync_pacer #(.SAMPLE_W(16), .DIFF_SYNC(1'b1), .INT_PER(INT_PER),
               .LOSS_CYC(LOSS)) uut_diff (
    .clk_i(clk_i), .reset_i(reset_i), .sync_i(sync_w),
    .sync_n_i(~sync_w), .sample_i(sample_i), .sample_req_o(sample_req_d),
    .ext_mode_o(ext_d), .ovs_en_o(), .record_o(rec_d), .txd_o());

  sync_source #(.HALF(HALF)) src (
    .clk_i(clk_i), .run_i(run), .glitch_i(glitch), .sync_o(sync_w));

  always #50 clk_i = ~clk_i;

  // ******************************************************
  // helpers
  // ******************************************************
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  function automatic logic [7:0] byte_of(logic [15:0] r, int k);
    return r[8*k +: 8];
  endfunction : byte_of

  task automatic cycles(int n);
    repeat (n) @(negedge clk_i);
  endtask : cycles

  // bounded wait so a dead pacer cannot hang the run
  task automatic wait_reqs(int n);
    for (int i = 0; i < 2000 && req_cnt < n; i++) @(negedge clk_i);
    check("req_wait", req_cnt >= n, 1'b1);
  endtask : wait_reqs

  // cycle count and hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      $display("[ERR] run_length expected done seen hang");
      stop_test();
    end
  end

  // capture pulses: count, spacing and record content
  always @(negedge clk_i) begin : req_mon
    if (sample_req_o === 1'b1) begin
      req_cnt++;
      req_gap  = cyc - last_req;
      last_req = cyc;
      if (ext_mode_o === 1'b1) check("record", record_o, exp_rec);
      else check("record_int", record_o, sample_i);
    end
    if (sample_req_d === 1'b1 && ext_d === 1'b1)
      check("record_diff", rec_d, exp_rec);
  end

  // frame decoder, sampling mid-bit at eight cycles a bit
  always begin : rx_mon
    logic [7:0] b;
    logic       p;
    @(negedge clk_i);
    if (txd_o === 1'b0 && reset_i === 1'b0) begin
      cycles(4);
      for (int i = 0; i < 8; i++) begin
        cycles(8);
        b[i] = txd_o;
      end
      cycles(8);
      p = txd_o;
      check("parity", p, ^b);
      cycles(8);
      check("stop", txd_o, 1'b1);
      rx_q.push_back(b);
    end
  end

  // ******************************************************
  // main sequence
  // ******************************************************
  initial begin : main
    void'($urandom(32'h058C1D79));
    sample_i = 16'h8001;
    cycles(20);
    reset_i = 1'b0;
    // free-running pacing before any sync edge
    wait_reqs(2);
    check("int_gap", req_gap, INT_PER);
    check("ext_idle", ext_mode_o, 1'b0);
    check("ovs_idle", ovs_en_o, 1'b1);
    // two-cycle blip is below the filter threshold
    glitch = 1'b1;
    cycles(2);
    glitch = 1'b0;
    cycles(10);
    check("ext_blip", ext_mode_o, 1'b0);
    cycles(38);
    run = 1'b1;
    @(posedge sync_w);
    req_cnt = 0;
    // one pass per sync period, timed by cycle count from the rise
    for (int k = 0; k < NPER; k++) begin
      exp_rec = sample_i;
      exp_q.push_back(sample_i);
      cycles(20);
      check("ext_on", ext_mode_o, 1'b1);
      check("ext_diff", ext_d, 1'b1);
      check("ovs_off", ovs_en_o, 1'b0);
      if (k > 0) check("ext_gap", req_gap, 2 * HALF);
      glitch = (k == 2);
      cycles(2);
      glitch = 1'b0;
      cycles(208);
      if (k == 0) rx_q.delete();
      sample_i = (k == 0) ? 16'hFFFF : 16'($urandom);
      if (k == NPER - 1) run = 1'b0;
      glitch = (k == 1);
      cycles(2);
      glitch = 1'b0;
      if (k < NPER - 1) cycles(168);
    end
    cycles(170);
    check("req_count", req_cnt, NPER);
    check("msg_bytes", rx_q.size(), 2 * NPER);
    if (rx_q.size() == 2 * NPER) begin
      for (int k = 0; k < NPER; k++) begin
        check("msg_lo", rx_q[2*k], byte_of(exp_q[k], 0));
        check("msg_hi", rx_q[2*k+1], byte_of(exp_q[k], 1));
      end
    end
    check("ext_hold", ext_mode_o, 1'b1);
    // quiet past the loss limit: back to internal pacing
    cycles(300);
    check("ext_lost", ext_mode_o, 1'b0);
    check("ext_diff_lost", ext_d, 1'b0);
    check("ovs_back", ovs_en_o, 1'b1);
    req_cnt = 0;
    wait_reqs(2);
    check("int_gap2", req_gap, INT_PER);
    stop_test();
  end
endmodule : testbench
